/* File: design/pmd_regs.sv */
// Pixel map definition register bank: select index, per-map base, width,
// height and format, the pixel interface defaults, and the video/system
// location check of the selected map.
// Assumes a strobe register port on ref_clk with read data one cycle later.
module pmd_regs (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Selected map definition towards the drawing engine.
    output logic      [1:0]  sel_map,
    output logic      [31:0] sel_base,
    output logic      [16:0] sel_width,
    output logic      [16:0] sel_height,
    output logic      [3:0]  sel_bpp,
    output logic             sel_big_end,
    output logic             sel_in_video,
    output logic             sel_limit_err
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Decode a format byte into depth, order and legality.
    function automatic pmd_pkg::pmd_fmt_t fmt_decode(input logic [7:0] f);
        pmd_pkg::pmd_fmt_t r;
        r.depth_code = f[1:0];
        r.big_end    = f[pmd_pkg::FMT_ORDER_BIT];
        r.legal      = (f[7:4] == 4'h0) && (f[2] == 1'b0);
        return r;
    endfunction : fmt_decode

    // Stored minus-one value back to a real count.
    function automatic logic [16:0] plus_one(input logic [15:0] v);
        return {1'b0, v} + 17'h0_0001;
    endfunction : plus_one

    // ****************************************************************
    // Plain registers
    // ****************************************************************
    logic [3:0]  sel_idx_q;     // Map selector.
    logic [7:0]  pix_ctrl_q;    // Pixel interface control.
    logic [7:0]  dest_cmp_q;    // Destination colour compare.
    logic [15:0] plane_mask_q;  // Pixel plane mask.
    logic [7:0]  carry_mask_q;  // Carry chain mask.
    logic [31:0] vmem_base_q;   // Video memory base.
    logic [31:0] vmem_size_q;   // Video memory size.
    logic [1:0]  sys_cfg_q;     // Slot width and translation mode.
    logic [31:0] page_off_q;    // Translation page offset.
    logic [31:0] rdata_q;       // Read data register.

    // ****************************************************************
    // Write decode
    // ****************************************************************
    // The master never raises two strobes together, so at most one is high.
    wire wr_sel    = reg_wr && (reg_addr == pmd_pkg::OFF_MAP_SELECT);
    wire wr_base   = reg_wr && (reg_addr == pmd_pkg::OFF_MAP_BASE);
    wire wr_width  = reg_wr && (reg_addr == pmd_pkg::OFF_MAP_WIDTH);
    wire wr_height = reg_wr && (reg_addr == pmd_pkg::OFF_MAP_HEIGHT);
    wire wr_format = reg_wr && (reg_addr == pmd_pkg::OFF_MAP_FORMAT);
    wire wr_map    = wr_base || wr_width || wr_height || wr_format;

    // Only codes 0..3 are maps; higher codes block map writes, but reads and outputs still follow map_idx.
    wire       sel_valid = (sel_idx_q[3:2] == 2'h0);
    wire [1:0] map_idx   = sel_idx_q[1:0];

    // ****************************************************************
    // Per-map storage
    // ****************************************************************
    pmd_pkg::pmd_map_t cur_map;  // Registered current definition.
    pmd_pkg::pmd_map_t new_map;  // Definition with one field replaced.

    // Merge the written field into the stored word of the chosen map.
    always_comb begin
        new_map = cur_map;
        if (wr_base) begin
            new_map.base = reg_wdata;
        end
        if (wr_width) begin
            new_map.width_m1 = reg_wdata[15:0];
        end
        if (wr_height) begin
            new_map.height_m1 = reg_wdata[15:0];
        end
        if (wr_format) begin
            new_map.format = reg_wdata[7:0];
        end
    end

    // The read index takes the written selector value during a selector write;
    // otherwise a map write just after a selector change would merge stale
    // fields, so the merge source is always the registered word of the same index.
    pmd_map_mem u_mem (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .wr_en   (wr_map && sel_valid),
        .wr_idx  (map_idx),
        .wr_data (new_map),
        .rd_idx  (wr_sel ? reg_wdata[1:0] : map_idx),
        .rd_data (cur_map)
    );

    // ****************************************************************
    // Control register writes
    // ****************************************************************
    // Short write process for the plain registers.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_idx_q    <= 4'h0;
            pix_ctrl_q   <= pmd_pkg::RST_PIX_IF_CTRL;
            dest_cmp_q   <= pmd_pkg::RST_DEST_CMP;
            plane_mask_q <= pmd_pkg::RST_PLANE_MASK;
            carry_mask_q <= pmd_pkg::RST_CARRY_MASK;
            vmem_base_q  <= pmd_pkg::RST_VMEM_BASE;
            vmem_size_q  <= pmd_pkg::RST_VMEM_SIZE;
            sys_cfg_q    <= 2'h0;
            page_off_q   <= 32'h0000_0000;
        end else if (reg_wr) begin
            unique case (reg_addr)
                pmd_pkg::OFF_MAP_SELECT:  sel_idx_q    <= reg_wdata[3:0];
                pmd_pkg::OFF_PIX_IF_CTRL: pix_ctrl_q   <= reg_wdata[7:0];
                pmd_pkg::OFF_DEST_CMP:    dest_cmp_q   <= reg_wdata[7:0];
                pmd_pkg::OFF_PLANE_MASK:  plane_mask_q <= reg_wdata[15:0];
                pmd_pkg::OFF_CARRY_MASK:  carry_mask_q <= reg_wdata[7:0];
                pmd_pkg::OFF_VMEM_BASE:   vmem_base_q  <= reg_wdata;
                pmd_pkg::OFF_VMEM_SIZE:   vmem_size_q  <= reg_wdata;
                pmd_pkg::OFF_SYS_CFG:     sys_cfg_q    <= reg_wdata[1:0];
                pmd_pkg::OFF_XLATE_ADDR:  page_off_q   <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Location check
    // ****************************************************************
    // Base goes through translation first, so the range test sees the
    // physical address when translation mode is on.
    logic [31:0] phys_base; // Translated base, one cycle behind cur_map.

    pmd_xlate u_xlate (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .xlate_en    (sys_cfg_q[pmd_pkg::CFG_VMT_BIT]),
        .page_offset (page_off_q),
        .lin_addr    (cur_map.base),
        .phys_q      (phys_base)
    );

    // Window test done in 33 bits so a window touching the top does not wrap.
    wire [32:0] vmem_end   = {1'b0, vmem_base_q} + {1'b0, vmem_size_q};
    wire        in_video   = (phys_base >= vmem_base_q) && ({1'b0, phys_base} < vmem_end);
    // System maps in a narrow slot must lie below the 16 Mbyte line.
    wire        limit_err  = !in_video && sys_cfg_q[pmd_pkg::CFG_SLOT16_BIT]
                             && (phys_base >= pmd_pkg::NARROW_LIMIT);
    pmd_pkg::pmd_fmt_t fmt;
    assign fmt = fmt_decode(cur_map.format);

    // ****************************************************************
    // Read mux
    // ****************************************************************
    // Status packs the location check beside the format legality bit.
    logic [31:0] rdata_d; // Next read word; unmapped offsets read zero.

    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (reg_addr)
            pmd_pkg::OFF_MAP_SELECT:  rdata_d = {28'h0, sel_idx_q};
            pmd_pkg::OFF_PIX_IF_CTRL: rdata_d = {24'h0, pix_ctrl_q};
            pmd_pkg::OFF_MAP_BASE:    rdata_d = cur_map.base;
            pmd_pkg::OFF_MAP_WIDTH:   rdata_d = {16'h0, cur_map.width_m1};
            pmd_pkg::OFF_MAP_HEIGHT:  rdata_d = {16'h0, cur_map.height_m1};
            pmd_pkg::OFF_MAP_FORMAT:  rdata_d = {24'h0, cur_map.format};
            pmd_pkg::OFF_DEST_CMP:    rdata_d = {24'h0, dest_cmp_q};
            pmd_pkg::OFF_PLANE_MASK:  rdata_d = {16'h0, plane_mask_q};
            pmd_pkg::OFF_CARRY_MASK:  rdata_d = {24'h0, carry_mask_q};
            pmd_pkg::OFF_VMEM_BASE:   rdata_d = vmem_base_q;
            pmd_pkg::OFF_VMEM_SIZE:   rdata_d = vmem_size_q;
            pmd_pkg::OFF_SYS_CFG:     rdata_d = {30'h0, sys_cfg_q};
            pmd_pkg::OFF_MAP_STATUS:  rdata_d = {29'h0, !fmt.legal, limit_err, in_video};
            pmd_pkg::OFF_XLATE_ADDR:  rdata_d = page_off_q;
            default:                  rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data stand for one cycle after the strobe, zero otherwise.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= reg_rd ? rdata_d : 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_q;

    // ****************************************************************
    // Selected map outputs
    // ****************************************************************
    // All map codes use the same output path, so A, B and C are
    // interchangeable as source, destination or pattern.
    logic [1:0]  sel_map_q;
    logic [31:0] sel_base_q;
    logic [16:0] sel_w_q;
    logic [16:0] sel_h_q;
    logic [3:0]  sel_bpp_q;
    logic        sel_be_q;
    logic        sel_vid_q;
    logic        sel_lim_q;

    // The location flags trail a base write by three cycles, one more than
    // the other fields, because of the translation register stage.
    // Registered so every output comes from a flip-flop.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_map_q  <= pmd_pkg::MAP_MASK;
            sel_base_q <= 32'h0000_0000;
            sel_w_q    <= 17'h0_0001;
            sel_h_q    <= 17'h0_0001;
            sel_bpp_q  <= 4'h8;
            sel_be_q   <= 1'b0;
            sel_vid_q  <= 1'b0;
            sel_lim_q  <= 1'b0;
        end else begin
            sel_map_q  <= map_idx;
            sel_base_q <= cur_map.base;
            sel_w_q    <= plus_one(cur_map.width_m1);
            sel_h_q    <= plus_one(cur_map.height_m1);
            sel_bpp_q  <= 4'(4'h1 << fmt.depth_code);
            sel_be_q   <= fmt.big_end;
            sel_vid_q  <= in_video;
            sel_lim_q  <= limit_err;
        end
    end

    assign sel_map       = sel_map_q;
    assign sel_base      = sel_base_q;
    assign sel_width     = sel_w_q;
    assign sel_height    = sel_h_q;
    assign sel_bpp       = sel_bpp_q;
    assign sel_big_end   = sel_be_q;
    assign sel_in_video  = sel_vid_q;
    assign sel_limit_err = sel_lim_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Width output carries the stored value plus one.
    a_width_plus_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sel_width == ($past(cur_map.width_m1) + 17'h0_0001))
        else $error("width output is not stored value plus one");

    // Height follows the same minus-one convention as width.
    a_height_plus_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sel_height == ($past(cur_map.height_m1) + 17'h0_0001))
        else $error("height output is not stored value plus one");

    // A selector write is kept in full, codes 4 to 15 included.
    a_select_stores: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_sel |=> (sel_idx_q == $past(reg_wdata[3:0])))
        else $error("selector write not stored");

    // A base written and read two cycles later comes back whole.
    a_base_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_base && sel_valid) ##1 !wr_map && !wr_sel ##1 (reg_rd && reg_addr == pmd_pkg::OFF_MAP_BASE)
        |=> (reg_rdata == $past(reg_wdata, 3)))
        else $error("base read back differs from written value");

    // A map flagged as video may not sit below the window base.
    a_video_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sel_in_video |-> ($past(phys_base) >= $past(vmem_base_q)))
        else $error("map flagged video below window base");

    // The window is half open: its last byte is base plus size minus one.
    a_video_upper: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sel_in_video |-> ({1'b0, $past(phys_base)} < $past(vmem_end)))
        else $error("map flagged video past window end");

    // Only a system map past the 16 Mbyte line may raise the limit flag.
    a_narrow_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sel_limit_err |-> (!sel_in_video && $past(phys_base) >= pmd_pkg::NARROW_LIMIT))
        else $error("limit flag without high system address");

    // A wide slot reaches all of memory, so the flag needs the narrow slot.
    a_limit_needs_slot: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sel_limit_err |-> $past(sys_cfg_q[pmd_pkg::CFG_SLOT16_BIT]))
        else $error("limit flag raised in a wide slot");

    // The widest big-end code must give eight bits per pixel.
    a_bpp_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(cur_map.format) == 8'h0B |-> (sel_bpp == 4'h8 && sel_big_end))
        else $error("format 0Bh not decoded as 8 bpp big-end");

    // With translation off the compare sees the linear base unchanged.
    a_no_xlate_pass: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !$past(sys_cfg_q[pmd_pkg::CFG_VMT_BIT]) |-> (phys_base == $past(cur_map.base)))
        else $error("address changed with translation off");

    // Codes 4 to 15 clear sel_valid, so map writes leave storage alone.
    a_bad_sel_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_map && !sel_valid) |=> $stable(cur_map) || $past(wr_sel))
        else $error("map changed while no map selected");

    // A field write lands in the chosen slot and shows on the next cycle.
    a_write_steered: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_map && sel_valid) |=> (cur_map == $past(new_map)))
        else $error("map write did not reach the selected slot");

    // The map code output follows the selector's low bits a cycle later.
    a_map_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 (sel_map == $past(map_idx)))
        else $error("selected map code not forwarded");

    // Main scenarios: map C chosen, both location outcomes, translation, bad format.
    c_select_c: cover property (@(posedge ref_clk) disable iff (!rst_n) wr_sel && reg_wdata[3:0] == 4'h3);
    c_in_video: cover property (@(posedge ref_clk) disable iff (!rst_n) sel_in_video);
    c_limit_hit: cover property (@(posedge ref_clk) disable iff (!rst_n) sel_limit_err);
    c_xlate_on: cover property (@(posedge ref_clk) disable iff (!rst_n) sys_cfg_q[pmd_pkg::CFG_VMT_BIT] && wr_base);
    c_bad_format: cover property (@(posedge ref_clk) disable iff (!rst_n) !fmt.legal);

endmodule : pmd_regs

/* File: design/pmd_pkg.sv */
// Package for the pixel map definition register bank.
// Assumes a single 40 MHz clock and a simple strobe register port with byte offsets.
package pmd_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] OFF_PIX_IF_CTRL   = 8'h11; // Pixel interface control.
    localparam logic [7:0] OFF_MAP_SELECT    = 8'h12; // Map select index.
    localparam logic [7:0] OFF_MAP_BASE      = 8'h14; // Map base byte address.
    localparam logic [7:0] OFF_MAP_WIDTH     = 8'h18; // Map width minus one.
    localparam logic [7:0] OFF_MAP_FORMAT    = 8'h1C; // Map pixel format.
    localparam logic [7:0] OFF_MAP_HEIGHT    = 8'h20; // Map height minus one.
    localparam logic [7:0] OFF_DEST_CMP      = 8'h4A; // Destination colour compare.
    localparam logic [7:0] OFF_PLANE_MASK    = 8'h50; // Pixel plane mask.
    localparam logic [7:0] OFF_CARRY_MASK    = 8'h54; // Carry chain mask.
    localparam logic [7:0] OFF_VMEM_BASE     = 8'h60; // Video memory base address.
    localparam logic [7:0] OFF_VMEM_SIZE     = 8'h64; // Video memory size in bytes.
    localparam logic [7:0] OFF_SYS_CFG       = 8'h68; // Slot width and translation mode.
    localparam logic [7:0] OFF_MAP_STATUS    = 8'h6C; // Location status of the selected map.
    localparam logic [7:0] OFF_XLATE_ADDR    = 8'h70; // Translation page offset.

    // ****************************************************************
    // Field positions and codes
    // ****************************************************************
    localparam int          CFG_SLOT16_BIT   = 0;      // Set when the slot is 16 bits wide.
    localparam int          CFG_VMT_BIT      = 1;      // virtual_memory_translation_mode.
    localparam int          ST_IN_VIDEO_BIT  = 0;      // Selected map lies in video memory.
    localparam int          ST_LIMIT_BIT     = 1;      // System map above the narrow-slot limit.
    localparam int          ST_FMT_BAD_BIT   = 2;      // Format code is not a legal one.
    localparam int          FMT_ORDER_BIT    = 3;      // Set selects big-end order.
    localparam logic [31:0] NARROW_LIMIT     = 32'h0100_0000; // 16 Mbyte line.
    localparam logic [1:0]  MAP_MASK         = 2'h0;   // Mask map code.

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0]  RST_PIX_IF_CTRL  = 8'h00;
    localparam logic [7:0]  RST_DEST_CMP     = 8'h04;
    localparam logic [15:0] RST_PLANE_MASK   = 16'h00FF;
    localparam logic [7:0]  RST_CARRY_MASK   = 8'hFF;
    localparam logic [31:0] RST_VMEM_BASE    = 32'h0000_0000;
    localparam logic [31:0] RST_VMEM_SIZE    = 32'h0010_0000;
    localparam logic [7:0]  RST_MAP_FORMAT   = 8'h03;

    // ****************************************************************
    // Types
    // ****************************************************************
    // One map definition as stored per map.
    typedef struct packed {
        logic [31:0] base;
        logic [15:0] width_m1;
        logic [15:0] height_m1;
        logic [7:0]  format;
    } pmd_map_t;

    // Register port request.
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pmd_req_t;

    // Decoded format of a map.
    typedef struct packed {
        logic [1:0] depth_code; // 0..3 gives 1, 2, 4, 8 bits per pixel.
        logic       big_end;
        logic       legal;
    } pmd_fmt_t;

endpackage : pmd_pkg

/* File: design/pmd_map_mem.sv */
// Storage of the four map definitions, one word per map.
// Assumes writes and reads on ref_clk; read data come out of a register.
module pmd_map_mem (
    // Clock and reset.
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    // Write side.
    input  wire logic             wr_en,
    input  wire logic [1:0]       wr_idx,
    input  wire pmd_pkg::pmd_map_t wr_data,
    // Read side.
    input  wire logic [1:0]       rd_idx,
    output pmd_pkg::pmd_map_t     rd_data
);

    // ****************************************************************
    // Storage array
    // ****************************************************************
    pmd_pkg::pmd_map_t mem_q [4]; // One definition per map.
    pmd_pkg::pmd_map_t rd_q;      // Registered read word.

    // Each map has its own slot; only the addressed slot changes.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                mem_q[i] <= '{32'h0000_0000, 16'h0000, 16'h0000, pmd_pkg::RST_MAP_FORMAT};
            end
        end else if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
        end
    end

    // Registered read, so the data follow the index by one cycle.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= '{32'h0000_0000, 16'h0000, 16'h0000, pmd_pkg::RST_MAP_FORMAT};
        end else if (wr_en && (wr_idx == rd_idx)) begin
            rd_q <= wr_data; // Write-through keeps the view current.
        end else begin
            rd_q <= mem_q[rd_idx];
        end
    end

    assign rd_data = rd_q;

endmodule : pmd_map_mem

/* File: design/pmd_xlate.sv */
// Linear-to-physical translation of a map base for the location check.
// Assumes a flat window: linear addresses map by adding a software-set offset.
module pmd_xlate (
    // Clock and reset.
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Translation control.
    input  wire logic        xlate_en,
    input  wire logic [31:0] page_offset,
    // Address in, address out.
    input  wire logic [31:0] lin_addr,
    output logic      [31:0] phys_q
);

    // ****************************************************************
    // Translation stage
    // ****************************************************************
    // Page-granular offset: the low 12 bits pass through untouched.
    // A full page-table walk lives elsewhere; this is the compare path only.
    logic [31:0] phys_d; // Translated address.

    assign phys_d = xlate_en ? {lin_addr[31:12] + page_offset[31:12], lin_addr[11:0]} : lin_addr;

    // One register stage keeps the compare path short.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phys_q <= 32'h0000_0000;
        end else begin
            phys_q <= phys_d;
        end
    end

endmodule : pmd_xlate

/* File: sim/pmd_regs_tb.sv */
// Self-checking bench for the pixel map definition register bank.
// Assumes pmd_pkg and pmd_regs are compiled first; one 40 MHz clock.
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, act, exp); end end

module pmd_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************************************
    // Signals and table
    // ****************************************************************
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] exp;
    } pmd_row_t;

    logic        ref_clk = 1'b0;  // Bench clock.
    logic        rst_n   = 1'b0;  // Active-low reset.
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata, sel_base, rd;
    logic [1:0]  sel_map;
    logic [16:0] sel_width, sel_height;
    logic [3:0]  sel_bpp;
    logic        sel_big_end, sel_in_video, sel_limit_err;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    // Each row writes a register and reads it back; upper unused bits are dropped.
    pmd_row_t rows [8] = '{
        '{8'h12, 32'h00000001, 32'h00000001}, '{8'h14, 32'hFFFFFFFC, 32'hFFFFFFFC},
        '{8'h18, 32'hFFFF027F, 32'h0000027F}, '{8'h20, 32'h000001DF, 32'h000001DF},
        '{8'h1C, 32'h0000000B, 32'h0000000B}, '{8'h11, 32'h0000005A, 32'h0000005A},
        '{8'h4A, 32'h00000007, 32'h00000007}, '{8'h50, 32'h0000000F, 32'h0000000F}};
    logic [31:0] bases [4] = '{32'h00A00000, 32'h00AFFFFF, 32'h00B00000, 32'h01000000};

    pmd_regs pmd_regs_inst (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sel_map(sel_map), .sel_base(sel_base), .sel_width(sel_width), .sel_height(sel_height),
        .sel_bpp(sel_bpp), .sel_big_end(sel_big_end), .sel_in_video(sel_in_video),
        .sel_limit_err(sel_limit_err));

    // Clock and a cycle ceiling, so a hung bus cannot stall the run.
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            end_sim();
        end
    end

    // ****************************************************************
    // Bus tasks
    // ****************************************************************
    // One-cycle write strobe; the next access waits for a fresh edge.
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : bus_wr

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : bus_rd

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus_rd(8'h4A, rd);
        `CHK(rd, 32'h00000004)
        bus_rd(8'h50, rd);
        `CHK(rd, 32'h000000FF)
        bus_rd(8'h54, rd);
        `CHK(rd, 32'h000000FF)
        bus_rd(8'h14, rd);
        `CHK(rd, 32'h00000000)
        `CHK(sel_width, 17'h00001)
        foreach (rows[i]) begin
            bus_wr(rows[i].addr, rows[i].wdata);
            bus_rd(rows[i].addr, rd);
            `CHK(rd, rows[i].exp)
        end
        `CHK(sel_width, 17'h00280)
        `CHK(sel_height, 17'h001E0)
        bus_wr(8'h11, 32'h00000000);
        bus_rd(8'h11, rd);
        `CHK(rd, 32'h00000000)
        // Map B gets its own width; map A must keep 640, code 5 changes nothing.
        bus_wr(8'h12, 32'h00000002);
        bus_wr(8'h18, 32'h00000013);
        bus_wr(8'h12, 32'h00000005);
        bus_wr(8'h18, 32'h00000077);
        bus_wr(8'h12, 32'h00000001);
        bus_rd(8'h18, rd);
        `CHK(rd, 32'h0000027F)
        bus_wr(8'h12, 32'h00000002);
        repeat (3) @(posedge ref_clk);
        `CHK(sel_map, 2'h2)
        `CHK(sel_width, 17'h00014)
        // Every legal format code in both bit orders.
        for (int k = 0; k < 8; k++) begin
            bus_wr(8'h1C, {28'h0000000, k[2], 1'b0, k[1:0]});
            repeat (3) @(posedge ref_clk);
            `CHK(sel_bpp, 4'h1 << k[1:0])
            `CHK(sel_big_end, k[2])
        end
        // Video window edges, then the narrow-slot line at 16 Mbytes.
        bus_wr(8'h60, 32'h00A00000);
        bus_wr(8'h64, 32'h00100000);
        bus_wr(8'h68, 32'h00000001);
        for (int k = 0; k < 4; k++) begin
            bus_wr(8'h14, bases[k]);
            repeat (4) @(posedge ref_clk);
            `CHK(sel_in_video, k < 2)
            `CHK(sel_limit_err, k == 3)
            `CHK(sel_base, bases[k])
        end
        // Translation on: video memory is reached through a page offset.
        bus_wr(8'h70, 32'h00A00000);
        bus_wr(8'h68, 32'h00000003);
        bus_rd(8'h68, rd);
        `CHK(rd, 32'h00000003)
        bus_wr(8'h14, 32'h00000000);
        repeat (4) @(posedge ref_clk);
        `CHK(sel_in_video, 1'b1)
        bus_wr(8'h14, 32'h00A00000);
        repeat (4) @(posedge ref_clk);
        `CHK(sel_in_video, 1'b0)
        `CHK(sel_limit_err, 1'b1)
        bus_wr(8'h1C, 32'h00000004);
        bus_rd(8'h6C, rd);
        `CHK(rd, 32'h00000006)
        // A reset in mid-run restores the compare default.
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        bus_rd(8'h4A, rd);
        `CHK(rd, 32'h00000004)
        end_sim();
    end
endmodule : pmd_regs_tb
